/* vrfs_far_side.sv */
/* Far-side model: processor code stepping and switching-cycle pulses.
   Assumes a 50 MHz clock; the bench picks the ramp direction. */
`timescale 1ns/100ps
`default_nettype none
module vrfs_far_side (
    input wire logic clk, rst, zc_want,
    input wire logic [1:0] ramp,
    output logic [6:0] voltage_code,
    output wire logic switch_cycle, zero_cross
);
    // ==========
    // One LSB per 125 cycles (2.5 us), a switching pulse every 4 (5 across the wrap)
    logic [6:0] cnt_reg;
    assign switch_cycle = cnt_reg[1:0] == 2'h3;
    assign zero_cross = switch_cycle ? zc_want : cnt_reg[2]; // Not held between pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_reg <= 7'h00;
        else cnt_reg <= (cnt_reg == 7'h7C) ? 7'h00 : cnt_reg + 7'h01;
        if (rst) voltage_code <= 7'h40;
        else if (cnt_reg == 7'h7C && ramp != 2'h0) voltage_code <= voltage_code + (ramp[0] ? 7'h01 : 7'h7F);
    end
endmodule : vrfs_far_side
`default_nettype wire

/* vrfs_pkg.sv */
/*
 * Types of the regulator fault supervisor.
 * Assumes vrfs_regs.svh supplies the numeric constants.
 */
package vrfs_pkg;

    // ======================================================================
    // Light-load emulation state, one-hot
    // ======================================================================
    typedef enum logic [3:0] {
        VRFS_EMU_CCM   = 4'h1,
        VRFS_EMU_DRIVE = 4'h2,
        VRFS_EMU_WAIT  = 4'h4,
        VRFS_EMU_DCM   = 4'h8
    } vrfs_emu_state_t;

    // ======================================================================
    // Hard overvoltage crowbar state, one-hot
    // ======================================================================
    typedef enum logic [2:0] {
        VRFS_HOV_IDLE  = 3'h1,
        VRFS_HOV_CLAMP = 3'h2,
        VRFS_HOV_OFF   = 3'h4
    } vrfs_hov_state_t;

    // Index of each timed fault
    typedef enum logic [1:0] {
        VRFS_F_OC  = 2'h0,
        VRFS_F_IMB = 2'h1,
        VRFS_F_UV  = 2'h2,
        VRFS_F_OV  = 2'h3
    } vrfs_fault_t;

endpackage : vrfs_pkg

/* vrfs_qual_if.sv */
/*
 * Link between the supervisor and one fault qualification timer.
 * Assumes the owner drives condition and timebase tick on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface vrfs_qual_if;
    logic cond;
    logic tick;
    logic qualified;

    modport timer (input cond, input tick, output qualified);
    modport owner (output cond, output tick, input qualified);
endinterface : vrfs_qual_if

`default_nettype wire

/* vrfs_qual_timer.sv */
/*
 * Fault qualification timer: counts timebase ticks while its condition is
 * continuously present, restarts at zero whenever it drops.
 * Assumes tick is a one-cycle pulse on the common clock.
 */
`timescale 1ns/100ps
`default_nettype none

module vrfs_qual_timer #(
    parameter int WIDTH = 10,
    parameter logic [WIDTH-1:0] LIMIT = '1
) (
    input wire logic clk,
    input wire logic rst,
    vrfs_qual_if.timer q
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    // ======================================================================
    // Counter
    // ======================================================================
    // Saturates at the limit so the qualified level holds while cond stays
    always_comb begin
        cnt_next = cnt_reg;
        if (!q.cond) begin
            cnt_next = '0;
        end else if (q.tick && cnt_reg != LIMIT) begin
            cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign q.qualified = q.cond && (cnt_reg == LIMIT);

endmodule : vrfs_qual_timer

`default_nettype wire

/* vrfs_regs.svh */
/*
 * Named constants of the regulator fault supervisor: timebase, qualification
 * times, mode settings and the overcurrent threshold table.
 * Assumes a 50 MHz system clock. Threshold codes are in units of 0.01 uA.
 */
`ifndef VRFS_REGS_SVH
`define VRFS_REGS_SVH

// ==========
// Timebase
// ==========
`define VRFS_CLK_MHZ 50
`define VRFS_TICK_US 1
`define VRFS_TICK_CYCLES (`VRFS_CLK_MHZ * `VRFS_TICK_US)

// ==========
// Qualification times, in timebase ticks
// ==========
`define VRFS_OC_QUAL_US 120
`define VRFS_FLT_QUAL_MS 1
`define VRFS_OC_QUAL_TICKS (`VRFS_OC_QUAL_US / `VRFS_TICK_US)
`define VRFS_FLT_QUAL_TICKS ((`VRFS_FLT_QUAL_MS * 1000) / `VRFS_TICK_US)

// ==========
// Light-load emulation re-entry
// ==========
`define VRFS_ZERO_CROSS_RUN 3'h4

// ==========
// Phase counts and band codes
// ==========
`define VRFS_PH1 2'h1
`define VRFS_PH2 2'h2
`define VRFS_PH3 2'h3
`define VRFS_BAND_NONE 3'h0

// ==========
// Overcurrent thresholds per program band and phase count (0.01 uA)
// ==========
`define VRFS_OCP_B0_P1 14'h07D0
`define VRFS_OCP_B0_P2 14'h0FA0
`define VRFS_OCP_B0_P3 14'h1770
`define VRFS_OCP_B1_P1 14'h08DE
`define VRFS_OCP_B1_P2 14'h11B2
`define VRFS_OCP_B1_P3 14'h1A90
`define VRFS_OCP_B2_P1 14'h0816
`define VRFS_OCP_B2_P2 14'h1022
`define VRFS_OCP_B2_P3 14'h1838
`define VRFS_OCP_B3_P1 14'h0708
`define VRFS_OCP_B3_P2 14'h0E10
`define VRFS_OCP_B3_P3 14'h1518
`define VRFS_OCP_B4_P1 14'h07D0
`define VRFS_OCP_B4_P2 14'h0E95
`define VRFS_OCP_B4_P3 14'h15E0
`define VRFS_OCP_B5_P1 14'h08DE
`define VRFS_OCP_B5_P2 14'h0F1E
`define VRFS_OCP_B5_P3 14'h16A8
`define VRFS_OCP_B6_P1 14'h0816
`define VRFS_OCP_B6_P2 14'h10AE
`define VRFS_OCP_B6_P3 14'h1900
`define VRFS_OCP_B7_P1 14'h0708
`define VRFS_OCP_B7_P2 14'h1130
`define VRFS_OCP_B7_P3 14'h19C8

`endif

/* vrfs_supervisor.sv */
/*
 * Supervisory logic of a multiphase buck controller: mode selection,
 * light-load emulation re-entry, fast extra clock, fault qualification and
 * latching, hard overvoltage crowbar, thermal throttle and second feedback
 * capacitor switch.
 * Assumes all comparator flags are synchronous to clk; rst is the supply
 * power-on reset; analog sensing and ramp generation live outside.
 */
`timescale 1ns/100ps
`default_nettype none

`include "vrfs_regs.svh"

// Summary of operation
// - Rising code in emulation: drive up, return
// - Enter DISCONTINUOUS_CONDUCTION after four consecutive zero crossings
// - Falling code in emulation: stay, no pull-down
// - Output dip below filtered copy: extra clock
// - Overcurrent fault after 120 us continuous excess
// - Program band latched at start-up, held till disable
// - Threshold from band and phases; defaults 20/40/60
// - Way-overcurrent: tri-state PWM, power-good low immediately
// - Phase imbalance for 1 ms latches off
// - Undervoltage for 1 ms latches off
// - Overvoltage plus 200 mV for 1 ms faults
// - Latched fault: power-good low, switches off
// - Faults clear on disable or power-on reset
// - Above 1.55 V clamp low side until 0.85 V
// - Hard overvoltage cleared only by power-on reset
// - Hard overvoltage watch active whenever enabled
// - Thermistor low drives throttle output low only
// - Second feedback only in two-phase configuration
// - Switch closed two-phase, open single-phase
// - Open switch pin keeps tracking feedback node
// - Phases and emulation follow hint pins
module vrfs_supervisor #(
    parameter int TICK_CYCLES = `VRFS_TICK_CYCLES,
    parameter int QUAL_WIDTH = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regulator_enable,
    input wire logic [1:0] config_phases,
    input wire logic power_state_hint_n,
    input wire logic deep_sleep_request,
    input wire logic [6:0] voltage_code,
    input wire logic [2:0] comp_band,
    input wire logic target_reached,
    input wire logic switch_cycle,
    input wire logic zero_cross,
    input wire logic output_dip,
    input wire logic droop_over_ocp,
    input wire logic droop_over_way,
    input wire logic phase_current_sense_imbalance,
    input wire logic output_sense_under,
    input wire logic output_sense_over,
    input wire logic output_sense_above_hard,
    input wire logic output_sense_below_release,
    input wire logic thermistor_low,
    output logic power_good,
    output logic pwm_tristate,
    output logic low_side_on,
    output logic soft_start,
    output logic [1:0] active_phases,
    output logic light_load_emulation,
    output logic discontinuous_conduction,
    output logic continuous_conduction,
    output logic extra_clock,
    output logic [13:0] overcurrent_trip,
    output logic second_feedback_switch,
    output logic feedback_track,
    output logic thermal_throttle_n,
    output logic [3:0] fault_status,
    output logic way_overcurrent,
    output logic overvoltage_trip
);

    // ==========
    // Threshold lookup, shared by the live and the latched paths
    // ==========
    function automatic logic [13:0] ocp_lookup(input logic [2:0] band,
                                               input logic [1:0] ph);
        logic [13:0] t1;
        logic [13:0] t2;
        logic [13:0] t3;
        t1 = `VRFS_OCP_B0_P1;
        t2 = `VRFS_OCP_B0_P2;
        t3 = `VRFS_OCP_B0_P3;
        case (band)
            3'h1: begin t1 = `VRFS_OCP_B1_P1; t2 = `VRFS_OCP_B1_P2; t3 = `VRFS_OCP_B1_P3; end
            3'h2: begin t1 = `VRFS_OCP_B2_P1; t2 = `VRFS_OCP_B2_P2; t3 = `VRFS_OCP_B2_P3; end
            3'h3: begin t1 = `VRFS_OCP_B3_P1; t2 = `VRFS_OCP_B3_P2; t3 = `VRFS_OCP_B3_P3; end
            3'h4: begin t1 = `VRFS_OCP_B4_P1; t2 = `VRFS_OCP_B4_P2; t3 = `VRFS_OCP_B4_P3; end
            3'h5: begin t1 = `VRFS_OCP_B5_P1; t2 = `VRFS_OCP_B5_P2; t3 = `VRFS_OCP_B5_P3; end
            3'h6: begin t1 = `VRFS_OCP_B6_P1; t2 = `VRFS_OCP_B6_P2; t3 = `VRFS_OCP_B6_P3; end
            3'h7: begin t1 = `VRFS_OCP_B7_P1; t2 = `VRFS_OCP_B7_P2; t3 = `VRFS_OCP_B7_P3; end
            default: begin t1 = `VRFS_OCP_B0_P1; t2 = `VRFS_OCP_B0_P2; t3 = `VRFS_OCP_B0_P3; end
        endcase
        if (ph == `VRFS_PH3) begin
            return t3;
        end else if (ph == `VRFS_PH2) begin
            return t2;
        end
        return t1;
    endfunction : ocp_lookup

    // ==========
    // Timebase
    // ==========
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic tick_reg;
    logic tick_next;
    logic extra_armed_reg;

    // Free-running, so qualification never waits on switching activity
    always_comb begin
        tick_next = (div_reg == 16'(TICK_CYCLES - 1));
        div_next = tick_next ? 16'h0000 : div_reg + 16'h0001;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ==========
    // Enable tracking, program band latch, phase mode
    // ==========
    logic en_d_reg;
    logic band_valid_reg;
    logic band_valid_next;
    logic [2:0] band_reg;
    logic [2:0] band_next;
    logic [1:0] phases_next;
    logic de_req;

    // Band is caught by a clocked process at the enable rise, never at reset
    always_comb begin
        band_valid_next = band_valid_reg;
        band_next = band_reg;
        if (!regulator_enable) begin
            band_valid_next = 1'b0;
        end else if (!band_valid_reg) begin
            band_valid_next = 1'b1;
            band_next = comp_band;
        end
        // Dropping the hint sheds one phase; deep sleep forces one phase
        de_req = deep_sleep_request;
        phases_next = config_phases;
        if (deep_sleep_request) begin
            phases_next = `VRFS_PH1;
        end else if (!power_state_hint_n && config_phases != `VRFS_PH1) begin
            phases_next = config_phases - `VRFS_PH1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_d_reg <= 1'b0;
            band_valid_reg <= 1'b0;
            band_reg <= `VRFS_BAND_NONE;
        end else begin
            en_d_reg <= regulator_enable;
            band_valid_reg <= band_valid_next;
            band_reg <= band_next;
        end
    end

    // ==========
    // Light-load emulation and conduction mode
    // ==========
    vrfs_pkg::vrfs_emu_state_t emu_reg;
    vrfs_pkg::vrfs_emu_state_t emu_next;
    logic [6:0] code_reg;
    logic [2:0] zc_reg;
    logic [2:0] zc_next;

    // The code is held by the processor between single-LSB steps
    always_comb begin
        emu_next = emu_reg;
        zc_next = zc_reg;
        case (emu_reg)
            vrfs_pkg::VRFS_EMU_CCM: begin
                zc_next = 3'h0;
                if (de_req) begin
                    emu_next = vrfs_pkg::VRFS_EMU_WAIT;
                end
            end
            vrfs_pkg::VRFS_EMU_DRIVE: begin
                zc_next = 3'h0;
                if (!de_req) begin
                    emu_next = vrfs_pkg::VRFS_EMU_CCM;
                end else if (target_reached) begin
                    emu_next = vrfs_pkg::VRFS_EMU_WAIT;
                end
            end
            vrfs_pkg::VRFS_EMU_WAIT: begin
                if (switch_cycle) begin
                    zc_next = zero_cross ? zc_reg + 3'h1 : 3'h0;
                end
                if (!de_req) begin
                    emu_next = vrfs_pkg::VRFS_EMU_CCM;
                end else if (voltage_code > code_reg) begin
                    emu_next = vrfs_pkg::VRFS_EMU_DRIVE;
                end else if (zc_next == `VRFS_ZERO_CROSS_RUN) begin
                    emu_next = vrfs_pkg::VRFS_EMU_DCM;
                end
            end
            vrfs_pkg::VRFS_EMU_DCM: begin
                zc_next = 3'h0;
                if (!de_req) begin
                    emu_next = vrfs_pkg::VRFS_EMU_CCM;
                end else if (voltage_code > code_reg) begin
                    emu_next = vrfs_pkg::VRFS_EMU_DRIVE;
                end
                // A falling code leaves the state alone: no active pull-down
            end
            default: begin
                emu_next = vrfs_pkg::VRFS_EMU_CCM;
                zc_next = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emu_reg <= vrfs_pkg::VRFS_EMU_CCM;
            code_reg <= 7'h00;
            zc_reg <= 3'h0;
        end else begin
            emu_reg <= emu_next;
            code_reg <= voltage_code;
            zc_reg <= zc_next;
        end
    end

    // ==========
    // Qualified fault timers
    // ==========
    vrfs_qual_if q_if[4] ();
    logic [3:0] qual_cond;
    logic [3:0] qual_hit;

    // Gated by enable so a disable also restarts every timer
    assign qual_cond[vrfs_pkg::VRFS_F_OC] = regulator_enable && droop_over_ocp;
    assign qual_cond[vrfs_pkg::VRFS_F_IMB] = regulator_enable
        && phase_current_sense_imbalance;
    assign qual_cond[vrfs_pkg::VRFS_F_UV] = regulator_enable && output_sense_under;
    assign qual_cond[vrfs_pkg::VRFS_F_OV] = regulator_enable && output_sense_over;

    generate
        for (genvar i = 0; i < 4; i++) begin : g_qual
            localparam logic [QUAL_WIDTH-1:0] LIM = (i == 0) ?
                QUAL_WIDTH'(`VRFS_OC_QUAL_TICKS) : QUAL_WIDTH'(`VRFS_FLT_QUAL_TICKS);
            assign q_if[i].cond = qual_cond[i];
            assign q_if[i].tick = tick_reg;
            assign qual_hit[i] = q_if[i].qualified;
            vrfs_qual_timer #(
                .WIDTH(QUAL_WIDTH),
                .LIMIT(LIM)
            ) u_timer (
                .clk(clk),
                .rst(rst),
                .q(q_if[i].timer)
            );
        end
    endgenerate

    // ==========
    // Fault latches and hard overvoltage crowbar
    // ==========
    logic [3:0] fault_reg;
    logic [3:0] fault_next;
    logic way_reg;
    logic way_next;
    vrfs_pkg::vrfs_hov_state_t hov_reg;
    vrfs_pkg::vrfs_hov_state_t hov_next;
    logic any_fault;

    // Disable clears soft faults; the hard overvoltage state survives it
    always_comb begin
        fault_next = fault_reg | qual_hit;
        way_next = way_reg || (regulator_enable && droop_over_way);
        if (!regulator_enable) begin
            fault_next = 4'h0;
            way_next = 1'b0;
        end
        hov_next = hov_reg;
        case (hov_reg)
            vrfs_pkg::VRFS_HOV_IDLE: begin
                if (regulator_enable && output_sense_above_hard) begin
                    hov_next = vrfs_pkg::VRFS_HOV_CLAMP;
                end
            end
            vrfs_pkg::VRFS_HOV_CLAMP: begin
                if (output_sense_below_release) begin
                    hov_next = vrfs_pkg::VRFS_HOV_OFF;
                end
            end
            vrfs_pkg::VRFS_HOV_OFF: begin
                // Watched even with other faults latched; no exit but reset
                if (regulator_enable && output_sense_above_hard) begin
                    hov_next = vrfs_pkg::VRFS_HOV_CLAMP;
                end
            end
            default: begin
                hov_next = vrfs_pkg::VRFS_HOV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_reg <= 4'h0;
            way_reg <= 1'b0;
            hov_reg <= vrfs_pkg::VRFS_HOV_IDLE;
        end else begin
            fault_reg <= fault_next;
            way_reg <= way_next;
            hov_reg <= hov_next;
        end
    end

    assign any_fault = (fault_next != 4'h0) || way_next;

    // ==========
    // Registered outputs
    // ==========
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_good <= 1'b0;
            pwm_tristate <= 1'b1;
            low_side_on <= 1'b0;
            soft_start <= 1'b0;
            active_phases <= `VRFS_PH1;
            light_load_emulation <= 1'b0;
            discontinuous_conduction <= 1'b0;
            continuous_conduction <= 1'b1;
            extra_clock <= 1'b0;
            overcurrent_trip <= `VRFS_OCP_B0_P1;
            second_feedback_switch <= 1'b0;
            feedback_track <= 1'b0;
            thermal_throttle_n <= 1'b1;
            fault_status <= 4'h0;
            way_overcurrent <= 1'b0;
            overvoltage_trip <= 1'b0;
        end else begin
            // Power-good needs enable, no latched fault and no crowbar history
            power_good <= regulator_enable && !any_fault
                && (hov_next == vrfs_pkg::VRFS_HOV_IDLE);
            // Tri-state unless running clean or clamping the low side
            pwm_tristate <= (hov_next != vrfs_pkg::VRFS_HOV_CLAMP)
                && (!regulator_enable || any_fault
                || hov_next == vrfs_pkg::VRFS_HOV_OFF);
            low_side_on <= (hov_next == vrfs_pkg::VRFS_HOV_CLAMP);
            soft_start <= regulator_enable && !en_d_reg;
            active_phases <= phases_next;
            light_load_emulation <= (emu_next == vrfs_pkg::VRFS_EMU_WAIT)
                || (emu_next == vrfs_pkg::VRFS_EMU_DCM);
            discontinuous_conduction <= (emu_next == vrfs_pkg::VRFS_EMU_DCM);
            continuous_conduction <= (emu_next == vrfs_pkg::VRFS_EMU_CCM)
                || (emu_next == vrfs_pkg::VRFS_EMU_DRIVE);
            extra_clock <= output_dip && !extra_armed_reg;
            // Live band before start-up, latched band after
            overcurrent_trip <= ocp_lookup(band_valid_next ? band_next : comp_band,
                phases_next);
            second_feedback_switch <= (config_phases == `VRFS_PH2)
                && (phases_next == `VRFS_PH2);
            feedback_track <= (config_phases == `VRFS_PH2)
                && (phases_next != `VRFS_PH2);
            thermal_throttle_n <= !thermistor_low;
            fault_status <= fault_next;
            way_overcurrent <= way_next;
            overvoltage_trip <= (hov_next != vrfs_pkg::VRFS_HOV_IDLE);
        end
    end

    // ==========
    // Dip edge memory for the one-shot extra clock
    // ==========

    // One pulse per dip; a held dip must not keep firing the modulator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extra_armed_reg <= 1'b0;
        end else begin
            extra_armed_reg <= output_dip;
        end
    end

endmodule : vrfs_supervisor

`default_nettype wire

/* vrfs_supervisor_assertions.sv */
/* Checker of the supervisor ports, bound to every instance.
   Assumes one clock domain; TICK_CYCLES is handed down. */
`timescale 1ns/100ps
`default_nettype none
module vrfs_supervisor_assertions #(parameter int TICK_CYCLES = 50) (
    input wire logic clk, rst, regulator_enable, droop_over_ocp, droop_over_way,
    input wire logic output_dip, output_sense_above_hard, thermistor_low,
    input wire logic power_good, pwm_tristate, low_side_on, extra_clock,
    input wire logic way_overcurrent, overvoltage_trip, thermal_throttle_n,
    input wire logic second_feedback_switch, feedback_track,
    input wire logic [3:0] fault_status
);
    // ==========
    // Length of the present overcurrent run, zero when it breaks
    int oc_run_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) oc_run_reg <= 0;
        else oc_run_reg <= (droop_over_ocp && regulator_enable) ? oc_run_reg + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_shut; !power_good && pwm_tristate; endsequence
    sequence s_clamp; low_side_on && !power_good && overvoltage_trip; endsequence
    a_way_trip: assert property (regulator_enable && droop_over_way |=> way_overcurrent ##0 s_shut)
        else $error("way trip missed");
    a_oc_early: assert property ($rose(fault_status[0]) |-> oc_run_reg >= 119 * TICK_CYCLES)
        else $error("overcurrent latched early");
    a_oc_late: assert property (oc_run_reg == 122 * TICK_CYCLES |-> fault_status[0])
        else $error("overcurrent latched late");
    a_crowbar_fast: assert property (regulator_enable && output_sense_above_hard |=> s_clamp)
        else $error("crowbar missed");
    a_hard_sticky: assert property (overvoltage_trip |=> overvoltage_trip)
        else $error("hard trip lost");
    a_fault_quiet: assert property (|fault_status |-> !power_good && (pwm_tristate || low_side_on))
        else $error("fault left switching");
    a_disable_clear: assert property (!regulator_enable |=> fault_status == 4'h0 && !way_overcurrent)
        else $error("fault not cleared");
    a_throttle_only: assert property (1'b1 |=> thermal_throttle_n != $past(thermistor_low))
        else $error("throttle wrong");
    a_extra_once: assert property ($rose(output_dip) |=> extra_clock ##1 !extra_clock)
        else $error("extra clock wrong");
    a_fb_track: assert property (feedback_track |-> !second_feedback_switch)
        else $error("track with switch closed");
endmodule : vrfs_supervisor_assertions
bind vrfs_supervisor vrfs_supervisor_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);
`default_nettype wire

/* vrfs_supervisor_bench.sv */
/* Self-checking bench of the supervisor with the far-side model.
   Assumes the checker file is compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module vrfs_supervisor_bench;
    logic clk = 1'b0, rst = 1'b1, regulator_enable = 1'b0, power_state_hint_n = 1'b1, zc_want = 1'b0;
    logic deep_sleep_request = 1'b0, target_reached = 1'b0, output_dip = 1'b0, thermistor_low = 1'b0;
    logic droop_over_ocp = 1'b0, droop_over_way = 1'b0, output_sense_above_hard = 1'b0;
    logic output_sense_below_release = 1'b0, overvoltage_trip, switch_cycle, zero_cross;
    logic [2:0] flt = 3'h0, comp_band = 3'h0;
    logic [1:0] config_phases = 2'h3, ramp = 2'h0, active_phases;
    logic [6:0] voltage_code;
    logic power_good, pwm_tristate, low_side_on, soft_start, light_load_emulation, extra_clock;
    logic discontinuous_conduction, continuous_conduction, second_feedback_switch, feedback_track;
    logic thermal_throttle_n, way_overcurrent;
    logic [13:0] overcurrent_trip;
    logic [3:0] fault_status;
    int errors = 0, checks = 0, cyc = 0, seed = 32'hb4ae9931;
    wire logic phase_current_sense_imbalance = flt[0];
    wire logic output_sense_under = flt[1];
    wire logic output_sense_over = flt[2];
    vrfs_supervisor #(.TICK_CYCLES(2)) vrfs_supervisor_i (.*);
    vrfs_far_side vrfs_far_side_i (.*);
    // ==========
    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            summarize();
        end
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic cmp(input logic [13:0] seen, input logic [13:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask : cmp
    task automatic summarize;
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // Threshold in 0.01 uA, no band or the fourth band
    function automatic logic [13:0] oc_want(input logic b4, input logic [1:0] ph);
        oc_want = (b4 && ph == 2'h3) ? 14'h15E0 : (b4 && ph == 2'h2) ? 14'h0E95 : 14'h07D0 * ph;
    endfunction : oc_want
    initial begin
        w(20);
        rst = 1'b0;
        for (int i = 0; i < 3; i++) begin
            power_state_hint_n = (i == 0);
            deep_sleep_request = (i == 2);
            w(2);
            cmp(active_phases, 14'(3 - i));
            cmp(overcurrent_trip, oc_want(1'b0, 2'(3 - i)));
        end
        {comp_band, regulator_enable, power_state_hint_n, deep_sleep_request} = 6'h26;
        w(2);
        comp_band = 3'h0;
        w(2);
        cmp(overcurrent_trip, oc_want(1'b1, 2'h3));
        power_state_hint_n = 1'b0;
        w(2);
        cmp(overcurrent_trip, oc_want(1'b1, 2'h2));
        config_phases = 2'h2;
        for (int i = 1; i >= 0; i--) begin
            power_state_hint_n = i[0];
            w(2);
            cmp(second_feedback_switch, 14'(i));
            cmp(feedback_track, 14'(1 - i));
        end
        {config_phases, power_state_hint_n, deep_sleep_request, ramp} = 6'h3D;
        w(130);
        cmp(continuous_conduction, 14'h1);
        {ramp, target_reached} = 3'h1;
        w(1);
        {target_reached, zc_want} = 2'h1;
        w(24);
        cmp(discontinuous_conduction, 14'h1);
        ramp = 2'h2;
        w(130);
        cmp(light_load_emulation, 14'h1);
        {ramp, deep_sleep_request, zc_want} = 4'h0;
        repeat (200) begin
            {thermistor_low, output_dip} = 2'($random(seed));
            w(1);
        end
        {thermistor_low, output_dip} = 2'h2;
        w(2);
        cmp({thermal_throttle_n, power_good}, 14'h1);
        {thermistor_low, droop_over_ocp} = 2'h1;
        w(200);
        droop_over_ocp = 1'b0;
        w(1);
        droop_over_ocp = 1'b1;
        w(200);
        cmp(fault_status, 14'h0);
        w(50);
        cmp({fault_status, pwm_tristate, power_good}, 14'h06);
        {droop_over_ocp, droop_over_way} = 2'h1;
        w(1);
        droop_over_way = 1'b0;
        w(1);
        cmp({way_overcurrent, power_good}, 14'h2);
        for (int i = 0; i < 3; i++) begin
            regulator_enable = 1'b0;
            w(2);
            cmp({fault_status, way_overcurrent}, 14'h0);
            regulator_enable = 1'b1;
            flt = 3'h1 << i;
            w(1);
            cmp(soft_start, 14'h1);
            w(1989);
            cmp(fault_status, 14'h0);
            w(20);
            cmp(fault_status, 14'h2 << i);
            flt = 3'h0;
        end
        output_sense_above_hard = 1'b1;
        w(1);
        output_sense_above_hard = 1'b0;
        w(2);
        cmp({low_side_on, pwm_tristate}, 14'h2);
        output_sense_below_release = 1'b1;
        w(2);
        cmp({low_side_on, pwm_tristate}, 14'h1);
        {output_sense_below_release, regulator_enable} = 2'h0;
        w(2);
        regulator_enable = 1'b1;
        w(2);
        cmp({overvoltage_trip, power_good}, 14'h2);
        rst = 1'b1;
        w(2);
        rst = 1'b0;
        w(2);
        cmp(overvoltage_trip, 14'h0);
        summarize();
    end
endmodule : vrfs_supervisor_bench
`default_nettype wire
